// *** src/pbh_pkg.sv ***
// Package of constants for the PLL B holdover, ramp and limit configuration bank
// ****************************************************************************
// Operation
// - Thirteen-bit phase detector delay across two bytes
// - Bit 1 picks loop closure or exit ramp
// - That method applies to free-run-to-lock transition
// - Bit 4 keeps or clears holdover history
// - Bit 5 freezes integrator or filter output
// - Six exit bandwidth bytes apply without ramping
// - New bandwidths load on strobe or full reset
// - Single-loop soft reset leaves bandwidths unchanged
// - Eight-bit hitless limit value, read/write
// - One bit selects hitless limit response
// - Scale code multiplies base ramp rate
// - Ramp enable bit ramps switching and holdover
// - Ramp enable clear means unramped transitions
// - Output limit enable and settle detect bits
// - Returning input clears then restarts history
// - Load strobe applies pending sets together
// ****************************************************************************
package pbh_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int NUM_REGS = 16; // Byte registers in the bank
	localparam int ADDR_W = 16; // Register address width
	localparam int DATA_W = 8; // Register data width
	localparam int BASE_RATE_W = 8; // Base ramp rate width
	localparam int RATE_FRAC_W = 2; // Fraction bits of the scaled rate
	localparam int RATE_W = BASE_RATE_W + 10 + RATE_FRAC_W; // Room for 1024x
	localparam int EXIT_BW_W = 48; // Six exit bandwidth bytes

	// Register indices
	localparam int IDX_PFD_LO = 0;
	localparam int IDX_PFD_HI = 1;
	localparam int IDX_HO_CFG = 2;
	localparam int IDX_HO_CTL = 3;
	localparam int IDX_BW0 = 4;
	localparam int IDX_HSW_LIM = 10;
	localparam int IDX_HSW_ACT = 11;
	localparam int IDX_RAMP = 12;
	localparam int IDX_OUT_CFG = 13;
	localparam int IDX_OMAX_LO = 14;
	localparam int IDX_OMAX_HI = 15;

	// Byte addresses, in index order
	localparam logic [NUM_REGS-1:0][ADDR_W-1:0] REG_ADDR = {
		16'h05AE, 16'h05AD, 16'h05AC, 16'h05A6, 16'h05A5, 16'h05A4,
		16'h05A2, 16'h05A1, 16'h05A0, 16'h059F, 16'h059E, 16'h059D,
		16'h059C, 16'h059B, 16'h058A, 16'h0589};

	// Implemented bits; the rest read as zero
	localparam logic [NUM_REGS-1:0][DATA_W-1:0] REG_MASK = {
		8'hFF, 8'hFF, 8'h09, 8'h0F, 8'h01, 8'hFF,
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
		8'hC0, 8'hF2, 8'h1F, 8'hFF};

	// Reset values
	localparam logic [DATA_W-1:0] HO_CFG_RESET = 8'hB2;
	localparam logic [NUM_REGS-1:0][DATA_W-1:0] REG_RESET = {
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, HO_CFG_RESET, 8'h00, 8'h00};

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int BIT_ACQ_METHOD = 1;
	localparam int BIT_KEEP_HIST = 4;
	localparam int BIT_FRZ_INT = 5;
	localparam int BIT_EXIT_BW_SEL = 6;
	localparam int BIT_EXIT_FIXED = 7;
	localparam int BIT_EXIT_TOOL = 6;
	localparam int BIT_RAMP_BYP = 7;
	localparam int BIT_HSW_RESP = 0;
	localparam int BIT_RAMP_EN = 3;
	localparam int BIT_OUT_LIM_EN = 0;
	localparam int BIT_SETTLE_EN = 3;
	localparam int PFD_HI_W = 5;

	// Ramp step scale codes
	localparam logic [2:0] SCALE_X1 = 3'h0;
	localparam logic [2:0] SCALE_X4 = 3'h1;
	localparam logic [2:0] SCALE_X16 = 3'h2;
	localparam logic [2:0] SCALE_X64 = 3'h3;
	localparam logic [2:0] SCALE_X256 = 3'h4;
	localparam logic [2:0] SCALE_X1024 = 3'h5;
	localparam logic [2:0] SCALE_QUARTER = 3'h6;
	localparam logic [2:0] SCALE_HALF = 3'h7;

	// History tracker states
	typedef enum logic [2:0] {
		HIST_IDLE = 3'b001,
		HIST_ACCUM = 3'b010,
		HIST_FROZEN = 3'b100
	} pbh_hist_e;

endpackage

// *** src/pbh_bw_shadow.sv ***
// Pending-to-active loader for the holdover exit bandwidth set
`timescale 1ns/1ns
module pbh_bw_shadow
	import pbh_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [EXIT_BW_W-1:0] pending_bw,
	input wire logic bandwidth_load_strobe,
	input wire logic full_soft_reset,
	input wire logic single_loop_soft_reset,
	output logic [EXIT_BW_W-1:0] active_bw
);

	// ****************************************************************
	// Active bandwidth set
	// ****************************************************************
	// Loads only on strobe or full reset; the single-loop reset is ignored
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			active_bw <= '0;
		end else if (bandwidth_load_strobe || full_soft_reset) begin
			active_bw <= pending_bw;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	AST_LOAD_ON_STROBE: assert property (
		bandwidth_load_strobe |=> active_bw == $past(pending_bw))
		else $error("active bandwidth not loaded by strobe");
	AST_HOLD_WITHOUT_LOAD: assert property (
		!bandwidth_load_strobe && !full_soft_reset |=> $stable(active_bw))
		else $error("active bandwidth changed without a load");
	AST_SINGLE_RESET_NO_LOAD: assert property (
		single_loop_soft_reset && !bandwidth_load_strobe && !full_soft_reset |=> $stable(active_bw))
		else $error("single-loop reset changed active bandwidth");
	COV_STROBE_LOAD: cover property (bandwidth_load_strobe && pending_bw != active_bw);

endmodule // pbh_bw_shadow

// *** src/pbh_ramp_scale.sv ***
// Final ramp rate from base rate and step scale code
`timescale 1ns/1ns
module pbh_ramp_scale
	import pbh_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [BASE_RATE_W-1:0] base_ramp_rate,
	input wire logic [2:0] ramp_step_scale,
	output logic [RATE_W-1:0] final_ramp_rate
);

	logic [RATE_W-1:0] base_ext; // Base rate with fraction bits
	logic [RATE_W-1:0] rate_nxt; // Scaled rate

	assign base_ext = {{(RATE_W-BASE_RATE_W-RATE_FRAC_W){1'b0}}, base_ramp_rate, {RATE_FRAC_W{1'b0}}};

	// ****************************************************************
	// Scale decode
	// ****************************************************************
	// Multipliers are powers of two, so each is a shift
	always_comb begin
		case (ramp_step_scale)
			SCALE_X1: rate_nxt = base_ext;
			SCALE_X4: rate_nxt = base_ext << 2;
			SCALE_X16: rate_nxt = base_ext << 4;
			SCALE_X64: rate_nxt = base_ext << 6;
			SCALE_X256: rate_nxt = base_ext << 8;
			SCALE_X1024: rate_nxt = base_ext << 10;
			SCALE_QUARTER: rate_nxt = base_ext >> 2;
			SCALE_HALF: rate_nxt = base_ext >> 1;
			default: rate_nxt = base_ext;
		endcase
	end

	// Registered result
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			final_ramp_rate <= '0;
		end else begin
			final_ramp_rate <= rate_nxt;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	AST_SCALE_1024: assert property (
		ramp_step_scale == SCALE_X1024 |=> final_ramp_rate == {$past(base_ramp_rate), 12'h000})
		else $error("1024x scale wrong");
	AST_SCALE_QUARTER: assert property (
		ramp_step_scale == SCALE_QUARTER |=> final_ramp_rate == {12'h000, $past(base_ramp_rate)})
		else $error("quarter scale wrong");
	COV_SCALE_HALF: cover property (ramp_step_scale == SCALE_HALF && base_ramp_rate != 8'h00);

endmodule // pbh_ramp_scale

// *** src/pbh_ramp_config.sv ***
// Top of the PLL B holdover, ramp and limit configuration bank
`timescale 1ns/1ns
module pbh_ramp_config
	import pbh_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	output logic [DATA_W-1:0] reg_rdata,
	output logic reg_hit,
	input wire logic bandwidth_load_strobe,
	input wire logic full_soft_reset,
	input wire logic single_loop_soft_reset,
	input wire logic [BASE_RATE_W-1:0] base_ramp_rate,
	input wire logic input_lost_or_switched,
	input wire logic valid_input_return,
	input wire logic free_run_to_lock,
	output logic [12:0] phase_detector_enable_delay,
	output logic lock_acquisition_method,
	output logic closure_ramp_active,
	output logic keep_holdover_history,
	output logic freeze_integrator_only,
	output logic exit_bandwidth_select,
	output logic exit_fixed_setting,
	output logic exit_tool_setting,
	output logic ramp_bypass_without_history,
	output logic [EXIT_BW_W-1:0] exit_bandwidth_parameters,
	output logic exit_bandwidth_in_use,
	output logic [7:0] hitless_limit_value,
	output logic hitless_limit_response,
	output logic [2:0] ramp_step_scale,
	output logic ramped_switching_enable,
	output logic [RATE_W-1:0] final_ramp_rate,
	output logic output_limit_enable,
	output logic settle_detect_enable,
	output logic [15:0] output_max_limit,
	output logic history_clear,
	output logic history_accumulate
);

	// ****************************************************************
	// Register storage
	// ****************************************************************
	logic [NUM_REGS-1:0][DATA_W-1:0] regs_r; // Byte registers
	logic [NUM_REGS-1:0] hit; // Address match per register
	logic [DATA_W-1:0] rdata_nxt; // Read data before the register
	logic [EXIT_BW_W-1:0] pending_bw; // Written exit bandwidth set
	pbh_hist_e hist_r; // History tracker state
	pbh_hist_e hist_nxt; // History tracker next state
	logic clear_nxt; // History clear request

	// One flip-flop byte per register, reserved bits held at zero
	for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
		assign hit[i] = (reg_addr == REG_ADDR[i]);
		// Byte write with mask of implemented bits
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				regs_r[i] <= REG_RESET[i];
			end else if (reg_wr_en && hit[i]) begin
				regs_r[i] <= reg_wdata & REG_MASK[i];
			end
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************
	// Unmapped addresses read zero
	always_comb begin
		rdata_nxt = '0;
		for (int j = 0; j < NUM_REGS; j++) begin
			if (hit[j]) begin
				rdata_nxt = regs_r[j];
			end
		end
	end

	// Read data is registered, one cycle after the request
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= '0;
			reg_hit <= 1'b0;
		end else if (reg_rd_en) begin
			reg_rdata <= rdata_nxt;
			reg_hit <= |hit;
		end
	end

	// ****************************************************************
	// Field decode
	// ****************************************************************
	// Low byte at the lower address
	assign phase_detector_enable_delay = {regs_r[IDX_PFD_HI][PFD_HI_W-1:0], regs_r[IDX_PFD_LO]};
	assign lock_acquisition_method = regs_r[IDX_HO_CFG][BIT_ACQ_METHOD];
	assign keep_holdover_history = regs_r[IDX_HO_CFG][BIT_KEEP_HIST];
	assign freeze_integrator_only = regs_r[IDX_HO_CFG][BIT_FRZ_INT];
	assign exit_bandwidth_select = regs_r[IDX_HO_CFG][BIT_EXIT_BW_SEL];
	// Software must keep this at one; it is stored as written
	assign exit_fixed_setting = regs_r[IDX_HO_CFG][BIT_EXIT_FIXED];
	assign exit_tool_setting = regs_r[IDX_HO_CTL][BIT_EXIT_TOOL];
	assign ramp_bypass_without_history = regs_r[IDX_HO_CTL][BIT_RAMP_BYP];
	assign hitless_limit_value = regs_r[IDX_HSW_LIM];
	assign hitless_limit_response = regs_r[IDX_HSW_ACT][BIT_HSW_RESP];
	assign ramp_step_scale = regs_r[IDX_RAMP][2:0];
	assign ramped_switching_enable = regs_r[IDX_RAMP][BIT_RAMP_EN];
	assign output_limit_enable = regs_r[IDX_OUT_CFG][BIT_OUT_LIM_EN];
	assign settle_detect_enable = regs_r[IDX_OUT_CFG][BIT_SETTLE_EN];
	assign output_max_limit = {regs_r[IDX_OMAX_HI], regs_r[IDX_OMAX_LO]};

	// Six exit bandwidth bytes, first byte lowest
	for (genvar k = 0; k < 6; k++) begin : g_bw
		assign pending_bw[k*8 +: 8] = regs_r[IDX_BW0 + k];
	end

	// Exit bandwidth only governs exit while ramping is off
	assign exit_bandwidth_in_use = !ramped_switching_enable;

	// ****************************************************************
	// Free-run to lock closure
	// ****************************************************************
	// Exit ramp used for the free-run-to-lock step only when selected
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			closure_ramp_active <= 1'b0;
		end else begin
			closure_ramp_active <= free_run_to_lock && lock_acquisition_method;
		end
	end

	// ****************************************************************
	// Bandwidth loader and ramp scaler
	// ****************************************************************
	pbh_bw_shadow u_bw_shadow (
		.clk(clk),
		.sys_rst(sys_rst),
		.pending_bw(pending_bw),
		.bandwidth_load_strobe(bandwidth_load_strobe),
		.full_soft_reset(full_soft_reset),
		.single_loop_soft_reset(single_loop_soft_reset),
		.active_bw(exit_bandwidth_parameters)
	);

	pbh_ramp_scale u_ramp_scale (
		.clk(clk),
		.sys_rst(sys_rst),
		.base_ramp_rate(base_ramp_rate),
		.ramp_step_scale(ramp_step_scale),
		.final_ramp_rate(final_ramp_rate)
	);

	// ****************************************************************
	// Holdover history tracker
	// ****************************************************************
	// Accumulates while a valid input is present, stops on loss or switch
	always_comb begin
		hist_nxt = hist_r;
		clear_nxt = 1'b0;
		case (hist_r)
			HIST_IDLE: begin
				if (valid_input_return) begin
					hist_nxt = HIST_ACCUM;
					clear_nxt = 1'b1;
				end
			end
			HIST_ACCUM: begin
				if (input_lost_or_switched) begin
					hist_nxt = HIST_FROZEN;
					clear_nxt = !keep_holdover_history;
				end
			end
			HIST_FROZEN: begin
				if (valid_input_return) begin
					hist_nxt = HIST_ACCUM;
					clear_nxt = 1'b1;
				end
			end
			default: begin
				hist_nxt = HIST_IDLE;
			end
		endcase
	end

	// State and registered clear pulse
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hist_r <= HIST_IDLE;
			history_clear <= 1'b0;
		end else begin
			hist_r <= hist_nxt;
			history_clear <= clear_nxt;
		end
	end

	assign history_accumulate = (hist_r == HIST_ACCUM) && !history_clear;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	AST_PFD_SPLIT: assert property (
		reg_wr_en && reg_addr == REG_ADDR[IDX_PFD_HI] |=>
		phase_detector_enable_delay[12:8] == $past(reg_wdata[4:0]))
		else $error("phase detector delay high bits wrong");
	AST_DEFAULTS: assert property (
		$past(sys_rst) |-> lock_acquisition_method && keep_holdover_history && freeze_integrator_only)
		else $error("holdover exit defaults wrong");
	AST_CLOSURE: assert property (
		free_run_to_lock && lock_acquisition_method |=> closure_ramp_active)
		else $error("closure ramp not raised");
	AST_FREEZE_BIT: assert property (
		reg_wr_en && reg_addr == REG_ADDR[IDX_HO_CFG] |=> freeze_integrator_only == $past(reg_wdata[5]))
		else $error("freeze source bit not written");
	AST_EXIT_BW_GATE: assert property (
		reg_wr_en && reg_addr == REG_ADDR[IDX_RAMP] |=> exit_bandwidth_in_use == !$past(reg_wdata[3]))
		else $error("exit bandwidth use not following ramp enable");
	AST_READBACK: assert property (
		reg_wr_en && reg_addr == REG_ADDR[IDX_HSW_LIM] ##1 reg_rd_en && reg_addr == REG_ADDR[IDX_HSW_LIM]
		|=> reg_rdata == $past(reg_wdata, 2))
		else $error("hitless limit readback wrong");
	AST_LIMIT_RESP: assert property (
		reg_wr_en && reg_addr == REG_ADDR[IDX_HSW_ACT] |=> hitless_limit_response == $past(reg_wdata[0]))
		else $error("limit response bit not written");
	AST_RAMP_EN: assert property (
		reg_wr_en && reg_addr == REG_ADDR[IDX_RAMP] && reg_wdata[3] |=> ramped_switching_enable)
		else $error("ramp enable not set");
	AST_OUT_CFG: assert property (
		reg_wr_en && reg_addr == REG_ADDR[IDX_OUT_CFG] |=>
		output_limit_enable == $past(reg_wdata[0]) && settle_detect_enable == $past(reg_wdata[3]))
		else $error("output limit config bits wrong");
	AST_HIST_RESTART: assert property (
		hist_r == HIST_FROZEN && valid_input_return |=> history_clear ##1 history_accumulate)
		else $error("history not cleared then restarted");
	AST_LOW_BYTE_FIRST: assert property (
		reg_wr_en && reg_addr == REG_ADDR[IDX_OMAX_LO] |=> output_max_limit[7:0] == $past(reg_wdata))
		else $error("low byte not at lower address");

	COV_HIST_CYCLE: cover property (hist_r == HIST_ACCUM ##1 hist_r == HIST_FROZEN ##[1:8] hist_r == HIST_ACCUM);
	COV_UNMAPPED_READ: cover property (reg_rd_en && !(|hit));
	COV_RAMPED: cover property (ramped_switching_enable && ramp_step_scale == SCALE_X1024);

endmodule // pbh_ramp_config

// *** bench/pbh_ramp_config_tb_top.sv ***
// Self-checking testbench for the PLL B holdover, ramp and limit configuration bank
`timescale 1ns/1ns
module pbh_ramp_config_tb_top
	import pbh_pkg::*;
;
	// ************************************************************************
	// Signals
	// ************************************************************************
	logic clk; // 20 MHz bench clock
	logic sys_rst; // Synchronous reset, active high
	logic reg_wr_en, reg_rd_en; // Register bus requests
	logic [ADDR_W-1:0] reg_addr; // Byte address
	logic [DATA_W-1:0] reg_wdata, reg_rdata; // Write and read data
	logic reg_hit; // Mapped address flag
	logic [4:0] ev; // Event pulses, one bit per event input
	wire logic bandwidth_load_strobe, full_soft_reset, single_loop_soft_reset;
	wire logic input_lost_or_switched, valid_input_return;
	logic [BASE_RATE_W-1:0] base_ramp_rate; // Base ramp rate level
	logic free_run_to_lock; // Free run to lock transition level
	logic [12:0] phase_detector_enable_delay;
	logic lock_acquisition_method, closure_ramp_active, keep_holdover_history, freeze_integrator_only;
	logic exit_bandwidth_select, exit_fixed_setting, exit_tool_setting, ramp_bypass_without_history;
	logic [EXIT_BW_W-1:0] exit_bandwidth_parameters;
	logic exit_bandwidth_in_use, hitless_limit_response, ramped_switching_enable;
	logic [7:0] hitless_limit_value;
	logic [2:0] ramp_step_scale;
	logic [RATE_W-1:0] final_ramp_rate;
	logic output_limit_enable, settle_detect_enable, history_clear, history_accumulate;
	logic [15:0] output_max_limit;
	int num_errors = 0; // Mismatches seen
	int tests_run = 0; // Comparisons made

	assign {valid_input_return, input_lost_or_switched, single_loop_soft_reset, full_soft_reset,
		bandwidth_load_strobe} = ev;

	// Table row: address, data written, readback expected, mapped flag
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic hit;
	} pbh_tb_row_s;
	localparam int NROWS = 18;
	pbh_tb_row_s rows [NROWS] = '{
		'{16'h0589, 8'hA5, 8'hA5, 1'b1}, '{16'h058A, 8'hFF, 8'h1F, 1'b1},
		'{16'h059B, 8'hCD, 8'hC0, 1'b1}, '{16'h059C, 8'hFF, 8'hC0, 1'b1},
		'{16'h059D, 8'h11, 8'h11, 1'b1}, '{16'h059E, 8'h22, 8'h22, 1'b1},
		'{16'h059F, 8'h33, 8'h33, 1'b1}, '{16'h05A0, 8'h44, 8'h44, 1'b1},
		'{16'h05A1, 8'h55, 8'h55, 1'b1}, '{16'h05A2, 8'h66, 8'h66, 1'b1},
		'{16'h05A3, 8'h77, 8'h00, 1'b0}, '{16'h05A4, 8'h5A, 8'h5A, 1'b1},
		'{16'h05A5, 8'hFF, 8'h01, 1'b1}, '{16'h05A6, 8'hFF, 8'h0F, 1'b1},
		'{16'h05AC, 8'hFF, 8'h09, 1'b1}, '{16'h05AD, 8'h34, 8'h34, 1'b1},
		'{16'h05AE, 8'h12, 8'h12, 1'b1}, '{16'h05AB, 8'hEE, 8'h00, 1'b0}};

	// ************************************************************************
	// Design under test
	// ************************************************************************
	pbh_ramp_config pbh_ramp_config_i (.clk, .sys_rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
		.reg_rdata, .reg_hit, .bandwidth_load_strobe, .full_soft_reset, .single_loop_soft_reset,
		.base_ramp_rate, .input_lost_or_switched, .valid_input_return, .free_run_to_lock,
		.phase_detector_enable_delay, .lock_acquisition_method, .closure_ramp_active,
		.keep_holdover_history, .freeze_integrator_only, .exit_bandwidth_select, .exit_fixed_setting,
		.exit_tool_setting, .ramp_bypass_without_history, .exit_bandwidth_parameters,
		.exit_bandwidth_in_use, .hitless_limit_value, .hitless_limit_response, .ramp_step_scale,
		.ramped_switching_enable, .final_ramp_rate, .output_limit_enable, .settle_detect_enable,
		.output_max_limit, .history_clear, .history_accumulate);

	// Clock generator
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ************************************************************************
	// Tasks
	// ************************************************************************
	// Verdict and end of run
	task automatic test_done();
		if (num_errors == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Compare a port value
	task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One byte write, request held across one rising edge
	task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr_en = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr_en = 1'b0;
	endtask

	// One byte read, then compare data and mapped flag
	task automatic chk_rd(input logic [15:0] a, input logic [7:0] exp, input logic exp_hit);
		@(negedge clk);
		reg_rd_en = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd_en = 1'b0;
		tests_run++;
		if (reg_rdata !== exp || reg_hit !== exp_hit) begin
			num_errors++;
			$display("ERROR read %h expected %h/%b seen %h/%b", a, exp, exp_hit, reg_rdata, reg_hit);
		end
	endtask

	// One-cycle event pulse
	task automatic pulse(input logic [4:0] m);
		@(negedge clk);
		ev = m;
		@(negedge clk);
		ev = 5'h00;
	endtask

	// Watchdog reckoned at about seventeen times the expected run length of some 175 cycles
	initial begin
		repeat (3000) @(posedge clk);
		num_errors++;
		test_done();
	end

	// ************************************************************************
	// Main sequence
	// ************************************************************************
	initial begin
		sys_rst = 1'b1;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 8'h00;
		ev = 5'h00;
		base_ramp_rate = 8'hFF;
		free_run_to_lock = 1'b0;
		repeat (8) @(negedge clk);
		sys_rst = 1'b0;
		// Reset values of every register
		for (int i = 0; i < NROWS; i++) begin
			chk_rd(rows[i].addr, (rows[i].addr == 16'h059B) ? 8'hB2 : 8'h00, rows[i].hit);
		end
		chk("lock_acquisition_method", 48'h1, 48'(lock_acquisition_method));
		chk("keep_holdover_history", 48'h1, 48'(keep_holdover_history));
		chk("freeze_integrator_only", 48'h1, 48'(freeze_integrator_only));
		chk("exit_fixed_setting", 48'h1, 48'(exit_fixed_setting));
		// Table of writes with readback of implemented bits
		for (int i = 0; i < NROWS; i++) begin
			reg_write(rows[i].addr, rows[i].wdata);
			chk_rd(rows[i].addr, rows[i].rdata, rows[i].hit);
		end
		chk("phase_detector_enable_delay", 48'h1FA5, 48'(phase_detector_enable_delay));
		chk("lock_acquisition_method", 48'h0, 48'(lock_acquisition_method));
		chk("keep_holdover_history", 48'h0, 48'(keep_holdover_history));
		chk("exit_bandwidth_select", 48'h1, 48'(exit_bandwidth_select));
		chk("exit_tool_setting", 48'h1, 48'(exit_tool_setting));
		chk("ramp_bypass_without_history", 48'h1, 48'(ramp_bypass_without_history));
		chk("hitless_limit_value", 48'h5A, 48'(hitless_limit_value));
		chk("hitless_limit_response", 48'h1, 48'(hitless_limit_response));
		chk("ramped_switching_enable", 48'h1, 48'(ramped_switching_enable));
		chk("exit_bandwidth_in_use", 48'h0, 48'(exit_bandwidth_in_use));
		chk("limit_and_settle", 48'h3, 48'({output_limit_enable, settle_detect_enable}));
		chk("output_max_limit", 48'h1234, 48'(output_max_limit));
		// Pending bandwidths load only on the strobe or a full soft reset
		chk("exit_bandwidth_parameters", 48'h0, exit_bandwidth_parameters);
		pulse(5'b00100);
		chk("exit_bandwidth_parameters", 48'h0, exit_bandwidth_parameters);
		pulse(5'b00001);
		chk("exit_bandwidth_parameters", 48'h665544332211, exit_bandwidth_parameters);
		reg_write(16'h059D, 8'h77);
		chk("exit_bandwidth_parameters", 48'h665544332211, exit_bandwidth_parameters);
		pulse(5'b00010);
		chk("exit_bandwidth_parameters", 48'h665544332277, exit_bandwidth_parameters);
		// Every ramp step scale code with ramping disabled
		for (int c = 0; c < 8; c++) begin
			reg_write(16'h05A6, {5'h00, 3'(c)});
			@(negedge clk);
			chk("final_ramp_rate", (c < 6) ? (48'h3FC << (2 * c)) : ((c == 6) ? 48'hFF : 48'h1FE),
				48'(final_ramp_rate));
			chk("exit_bandwidth_in_use", 48'h1, 48'(exit_bandwidth_in_use));
			chk("ramp_step_scale", 48'(c), 48'(ramp_step_scale));
			chk("ramped_switching_enable", 48'h0, 48'(ramped_switching_enable));
		end
		// Closure ramp follows the acquisition method on free run to lock
		free_run_to_lock = 1'b1;
		repeat (2) @(negedge clk);
		chk("closure_ramp_active", 48'h0, 48'(closure_ramp_active));
		reg_write(16'h059B, 8'hF2);
		@(negedge clk);
		chk("closure_ramp_active", 48'h1, 48'(closure_ramp_active));
		free_run_to_lock = 1'b0;
		// History: cleared on return, kept on loss while preserving
		pulse(5'b10000);
		chk("history_clear", 48'h1, 48'(history_clear));
		chk("history_accumulate", 48'h0, 48'(history_accumulate));
		@(negedge clk);
		chk("history_accumulate", 48'h1, 48'(history_accumulate));
		pulse(5'b01000);
		chk("history_clear", 48'h0, 48'(history_clear));
		chk("history_accumulate", 48'h0, 48'(history_accumulate));
		// Loss with history clearing selected
		reg_write(16'h059B, 8'h82);
		chk("freeze_integrator_only", 48'h0, 48'(freeze_integrator_only));
		pulse(5'b10000);
		@(negedge clk);
		pulse(5'b01000);
		chk("history_clear", 48'h1, 48'(history_clear));
		// Back-to-back write then read returns the new value
		@(negedge clk);
		reg_wr_en = 1'b1;
		reg_addr = 16'h05A4;
		reg_wdata = 8'hC3;
		@(negedge clk);
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b1;
		@(negedge clk);
		reg_rd_en = 1'b0;
		chk("hitless_limit_readback", 48'hC3, 48'(reg_rdata));
		// Reset in mid-run restores defaults and clears the active set
		@(negedge clk);
		sys_rst = 1'b1;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		chk_rd(16'h059B, 8'hB2, 1'b1);
		chk_rd(16'h05A4, 8'h00, 1'b1);
		chk("exit_bandwidth_parameters", 48'h0, exit_bandwidth_parameters);
		test_done();
	end

endmodule // pbh_ramp_config_tb_top
